// *** vout_vin_ot_limit_registers.sv ***
`timescale 1ns/1ps
`include "vout_limits_params.svh"

module vout_vin_ot_limit_registers #(
	parameter logic [6:0] SMB_ADDR      = `SMB_ADDR_DEFAULT,
	parameter int         OT_FILTER_CYC = `OT_DETECT_CYCLES - 1
) (
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	input  wire logic                  scl_in,
	input  wire logic                  sda_in,
	output logic                       sda_out,
	output logic                       sda_oe,
	output logic                       alert_out_n,
	output logic                       alert_oe,
	input  wire logic [7:0]            vin_meas,
	input  wire logic [`W_TEMP-1:0]    temp_meas,
	input  wire logic                  start_ok,
	output logic                       conv_enable,
	output logic                       thermal_shutdown,
	output logic [`W_VOUT-1:0]         vout_target,
	output logic [`W_VOUT+`W_RATIO-1:0] fb_ref
);

	// ************************************
	// registers
	// ************************************
	logic [`W_VOUT-1:0]   vout_command;
	logic [`W_RATIO-1:0]  feedback_divider_ratio;
	logic [`W_VOUT-1:0]   output_voltage_lower_limit;
	logic [`W_VIN_THR-1:0] input_start_threshold;
	logic [`W_VIN_THR-1:0] input_stop_threshold;
	logic [`W_TEMP-1:0]   overtemp_fault_limit;
	logic [7:0]           operation;
	logic [7:0]           ot_response;
	logic                 output_limit_warning_bit;
	logic                 overtemp_fault_flag;

	// ************************************
	// bus pin sampling
	// ************************************
	logic [1:0] pins_s;
	logic       scl_d;
	logic       sda_d;
	logic       scl_s;
	logic       sda_s;

	sync2 #(
		.WIDTH (2)
	) u_pin_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.d      ({scl_in, sda_in}),
		.q      (pins_s)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	// previous sampled levels for edge finding
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	// edges and start/stop conditions
	assign scl_rise  = scl_s & ~scl_d;
	assign scl_fall  = ~scl_s & scl_d;
	assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
	assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

	// ************************************
	// byte engine
	// ************************************
	vout_limits_pkg::smb_state_t state;
	logic [7:0] shreg;
	logic [3:0] bitcnt;
	logic       got_byte;
	logic       rw_read;
	logic [7:0] cmd;
	logic [1:0] idx;
	logic [7:0] data_lo;
	logic [7:0] tx;
	logic       drive_low;
	logic       master_ack;
	logic       wr_byte;
	logic       wr_word;
	logic       clr_faults;
	logic [15:0] rd_word;
	logic [7:0]  rd_byte;
	logic [7:0]  rd_byte_next;
	logic [7:0]  status_byte;
	logic [15:0] status_word;
	logic [7:0]  status_vout;

	// read data, unused upper bits forced to zero
	always_comb begin
		rd_word = 16'h0000;
		unique case (cmd)
			`CMD_OPERATION:    rd_word = {8'h00, operation};
			`CMD_VOUT_COMMAND: rd_word = 16'(vout_command);
			`CMD_FB_RATIO:     rd_word = 16'(feedback_divider_ratio);
			`CMD_VOUT_LOWER:   rd_word = 16'(output_voltage_lower_limit);
			`CMD_VIN_START:    rd_word = 16'(input_start_threshold);
			`CMD_VIN_STOP:     rd_word = 16'(input_stop_threshold);
			`CMD_OT_LIMIT:     rd_word = 16'(overtemp_fault_limit);
			`CMD_OT_RESPONSE:  rd_word = {8'h00, ot_response};
			`CMD_STATUS_BYTE:  rd_word = {8'h00, status_byte};
			`CMD_STATUS_WORD:  rd_word = status_word;
			`CMD_STATUS_VOUT:  rd_word = {8'h00, status_vout};
			default:           rd_word = 16'h0000;
		endcase
		rd_byte = idx[0] ? rd_word[15:8] : rd_word[7:0];
	end

	// bit level receive and state sequencing
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state      <= vout_limits_pkg::SMB_IDLE;
			shreg      <= 8'h00;
			bitcnt     <= 4'h0;
			got_byte   <= 1'b0;
			rw_read    <= 1'b0;
			cmd        <= 8'h00;
			idx        <= 2'h0;
			data_lo    <= 8'h00;
			tx         <= 8'h00;
			drive_low  <= 1'b0;
			master_ack <= 1'b0;
			wr_byte    <= 1'b0;
			wr_word    <= 1'b0;
			clr_faults <= 1'b0;
		end else begin
			wr_byte    <= 1'b0;
			wr_word    <= 1'b0;
			clr_faults <= 1'b0;
			if (bus_start) begin
				state     <= vout_limits_pkg::SMB_ADDR;
				bitcnt    <= 4'h0;
				got_byte  <= 1'b0;
				drive_low <= 1'b0;
			end else if (bus_stop) begin
				state     <= vout_limits_pkg::SMB_IDLE;
				drive_low <= 1'b0;
			end else if (scl_rise) begin
				// sample data bits and the master acknowledge
				shreg      <= {shreg[6:0], sda_s};
				master_ack <= ~sda_s;
				if (state != vout_limits_pkg::SMB_RDATA) begin
					bitcnt <= bitcnt + 4'h1;
					if (bitcnt == 4'h7) begin
						got_byte <= 1'b1;
					end
				end
			end else if (scl_fall) begin
				unique case (state)
					vout_limits_pkg::SMB_IDLE,
					vout_limits_pkg::SMB_SKIP: begin
						drive_low <= 1'b0;
					end
					vout_limits_pkg::SMB_ADDR: begin
						if (got_byte) begin
							got_byte <= 1'b0;
							bitcnt   <= 4'h0;
							if (shreg[7:1] == SMB_ADDR) begin
								rw_read   <= shreg[0];
								drive_low <= 1'b1;
								state     <= vout_limits_pkg::SMB_ADDR_ACK;
							end else begin
								state <= vout_limits_pkg::SMB_SKIP;
							end
						end
					end
					vout_limits_pkg::SMB_ADDR_ACK: begin
						if (rw_read) begin
							idx       <= 2'h0;
							drive_low <= ~rd_byte[7];
							tx        <= {rd_byte[6:0], 1'b0};
							bitcnt    <= 4'h1;
							state     <= vout_limits_pkg::SMB_RDATA;
						end else begin
							drive_low <= 1'b0;
							bitcnt    <= 4'h0; // ack bit is not a data bit
							state     <= vout_limits_pkg::SMB_CMD;
						end
					end
					vout_limits_pkg::SMB_CMD: begin
						if (got_byte) begin
							got_byte  <= 1'b0;
							bitcnt    <= 4'h0;
							cmd       <= shreg;
							idx       <= 2'h0;
							drive_low <= 1'b1;
							state     <= vout_limits_pkg::SMB_CMD_ACK;
						end
					end
					vout_limits_pkg::SMB_CMD_ACK: begin
						drive_low  <= 1'b0;
						bitcnt     <= 4'h0; // ack bit is not a data bit
						clr_faults <= (cmd == `CMD_CLEAR_FAULTS);
						state      <= vout_limits_pkg::SMB_WDATA;
					end
					vout_limits_pkg::SMB_WDATA: begin
						if (got_byte) begin
							got_byte  <= 1'b0;
							bitcnt    <= 4'h0;
							drive_low <= 1'b1;
							idx       <= (idx == 2'h3) ? idx : idx + 2'h1;
							if (idx == 2'h0) begin
								data_lo <= shreg;
								wr_byte <= 1'b1;
							end
							wr_word <= (idx == 2'h1);
							state   <= vout_limits_pkg::SMB_WDATA_ACK;
						end
					end
					vout_limits_pkg::SMB_WDATA_ACK: begin
						drive_low <= 1'b0;
						bitcnt    <= 4'h0; // ack bit is not a data bit
						state     <= vout_limits_pkg::SMB_WDATA;
					end
					vout_limits_pkg::SMB_RDATA: begin
						if (bitcnt == 4'h8) begin
							drive_low <= 1'b0;
							state     <= vout_limits_pkg::SMB_RDATA_ACK;
						end else begin
							drive_low <= ~tx[7];
							tx        <= {tx[6:0], 1'b0};
							bitcnt    <= bitcnt + 4'h1;
						end
					end
					vout_limits_pkg::SMB_RDATA_ACK: begin
						if (master_ack) begin
							idx       <= idx + 2'h1;
							drive_low <= ~rd_byte_next[7];
							tx        <= {rd_byte_next[6:0], 1'b0};
							bitcnt    <= 4'h1;
							state     <= vout_limits_pkg::SMB_RDATA;
						end else begin
							drive_low <= 1'b0;
							state     <= vout_limits_pkg::SMB_SKIP;
						end
					end
				endcase
			end
		end
	end

	// byte that follows the current one in a read
	assign rd_byte_next = idx[0] ? 8'h00 : rd_word[15:8];

	// open-drain data line, driven only low
	assign sda_out = 1'b0;
	assign sda_oe  = drive_low;

	// ************************************
	// register writes
	// ************************************
	logic [15:0]        wdata;
	logic [`W_VOUT-1:0] vout_req;
	logic               vout_clamp;

	assign wdata      = {shreg, data_lo};
	assign vout_req   = wdata[`W_VOUT-1:0];
	assign vout_clamp = wr_word && (cmd == `CMD_VOUT_COMMAND) &&
	                    (vout_req < output_voltage_lower_limit);

	// word commands, upper bits dropped
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			vout_command               <= `RST_VOUT_COMMAND;
			feedback_divider_ratio     <= `RST_FB_RATIO;
			output_voltage_lower_limit <= `RST_VOUT_LOWER;
			input_start_threshold      <= `RST_VIN_START;
			input_stop_threshold       <= `RST_VIN_STOP;
			overtemp_fault_limit       <= `RST_OT_LIMIT;
		end else if (wr_word) begin
			unique case (cmd)
				`CMD_VOUT_COMMAND: begin
					vout_command <= vout_clamp ? output_voltage_lower_limit : vout_req;
				end
				`CMD_FB_RATIO:   feedback_divider_ratio     <= wdata[`W_RATIO-1:0];
				`CMD_VOUT_LOWER: output_voltage_lower_limit <= wdata[`W_VOUT-1:0];
				`CMD_VIN_START:  input_start_threshold      <= wdata[`W_VIN_THR-1:0];
				`CMD_VIN_STOP:   input_stop_threshold       <= wdata[`W_VIN_THR-1:0];
				`CMD_OT_LIMIT:   overtemp_fault_limit       <= wdata[`W_TEMP-1:0];
				default: ;
			endcase
		end
	end

	logic oper_on_write;

	// a write of operation with the on bit set re-arms latch-off
	assign oper_on_write = wr_byte && (cmd == `CMD_OPERATION) && shreg[`BIT_OPER_ON];

	// byte commands
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			operation   <= `RST_OPERATION;
			ot_response <= `RST_OT_RESPONSE;
		end else if (wr_byte) begin
			if (cmd == `CMD_OPERATION) begin
				operation <= shreg;
			end
			if (cmd == `CMD_OT_RESPONSE) begin
				ot_response <= shreg;
			end
		end
	end

	// ************************************
	// input voltage window
	// ************************************
	logic vin_running;

	// start at or above start threshold with start_ok, stop at or below stop threshold
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			vin_running <= 1'b0;
		end else if (vin_running) begin
			if (vin_meas <= 8'(input_stop_threshold)) begin
				vin_running <= 1'b0;
			end
		end else if (vin_meas >= 8'(input_start_threshold) && start_ok) begin
			vin_running <= 1'b1;
		end
	end

	// ************************************
	// thermal protection
	// ************************************
	logic [`W_TEMP-1:0] ot_limit_eff;
	logic               ot_over_raw;
	logic               ot_over;
	logic               ot_cool_retry;
	logic               ot_cool_latch;
	logic               ot_reenable;
	vout_limits_pkg::ot_state_t ot_state;

	// limits above shutdown level fall back to reaching it
	assign ot_limit_eff  = (overtemp_fault_limit > `OT_SHUTDOWN_C) ?
	                       `OT_SHUTDOWN_C : overtemp_fault_limit;
	assign ot_over_raw   = (overtemp_fault_limit > `OT_SHUTDOWN_C) ?
	                       (temp_meas >= `OT_SHUTDOWN_C) :
	                       (temp_meas > overtemp_fault_limit);
	assign ot_cool_retry = ({1'b0, temp_meas} + `OT_RETRY_HYST_C) <
	                       {1'b0, ot_limit_eff};
	assign ot_cool_latch = temp_meas < ot_limit_eff;

	persist_filter #(
		.COUNT (OT_FILTER_CYC)
	) u_ot_filter (
		.clk       (clk),
		.arst_n    (arst_n),
		.level_in  (ot_over_raw),
		.level_out (ot_over)
	);

	// tracks a re-enable seen since the trip
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ot_reenable <= 1'b0;
		end else if (ot_state == vout_limits_pkg::OT_NORMAL) begin
			ot_reenable <= 1'b0;
		end else if (oper_on_write) begin
			ot_reenable <= 1'b1;
		end
	end

	// trip, then auto-retry or latch-off release
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ot_state <= vout_limits_pkg::OT_NORMAL;
		end else begin
			unique case (ot_state)
				vout_limits_pkg::OT_NORMAL: begin
					if (ot_over) begin
						ot_state <= vout_limits_pkg::OT_TRIPPED;
					end
				end
				vout_limits_pkg::OT_TRIPPED: begin
					if (ot_response[`BIT_OT_LATCH]) begin
						if (ot_cool_latch && (ot_reenable || oper_on_write)) begin
							ot_state <= vout_limits_pkg::OT_NORMAL;
						end
					end else if (ot_cool_retry) begin
						ot_state <= vout_limits_pkg::OT_NORMAL;
					end
				end
			endcase
		end
	end

	assign thermal_shutdown = (ot_state == vout_limits_pkg::OT_TRIPPED);

	// ************************************
	// status flags and alert
	// ************************************
	// sticky flags, a set wins over a clear in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			output_limit_warning_bit <= 1'b0;
			overtemp_fault_flag      <= 1'b0;
		end else begin
			if (vout_clamp) begin
				output_limit_warning_bit <= 1'b1;
			end else if (clr_faults) begin
				output_limit_warning_bit <= 1'b0;
			end
			if (ot_over && ot_state == vout_limits_pkg::OT_NORMAL) begin
				overtemp_fault_flag <= 1'b1;
			end else if (clr_faults) begin
				overtemp_fault_flag <= 1'b0;
			end
		end
	end

	// status views built from the flags and conv_enable
	always_comb begin
		status_byte                = 8'h00;
		status_byte[`BIT_SB_OFF]   = ~conv_enable;
		status_byte[`BIT_SB_TEMP]  = overtemp_fault_flag;
		status_word                = {8'h00, status_byte};
		status_word[`BIT_SW_VOUT]  = output_limit_warning_bit;
		status_vout                = 8'h00;
		status_vout[`BIT_SV_MAXMIN] = output_limit_warning_bit;
	end

	// alert held low while any flag stands
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			alert_out_n <= 1'b1;
		end else begin
			alert_out_n <= ~(output_limit_warning_bit | overtemp_fault_flag);
		end
	end

	assign alert_oe = ~alert_out_n;

	// ************************************
	// conversion control and reference
	// ************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			conv_enable <= 1'b0;
			vout_target <= `RST_VOUT_COMMAND;
			fb_ref      <= '0;
		end else begin
			conv_enable <= operation[`BIT_OPER_ON] & vin_running &
			               (ot_state == vout_limits_pkg::OT_NORMAL);
			vout_target <= vout_command;
			fb_ref      <= vout_command * feedback_divider_ratio;
		end
	end

endmodule : vout_vin_ot_limit_registers

// *** vout_limits_params.svh ***
`ifndef VOUT_LIMITS_PARAMS_SVH
`define VOUT_LIMITS_PARAMS_SVH

// ************************************
// command codes
// ************************************
`define CMD_OPERATION        8'h01
`define CMD_CLEAR_FAULTS     8'h03
`define CMD_VOUT_COMMAND     8'h21
`define CMD_FB_RATIO         8'h29
`define CMD_VOUT_LOWER       8'h2b
`define CMD_VIN_START        8'h35
`define CMD_VIN_STOP         8'h36
`define CMD_OT_LIMIT         8'h4f
`define CMD_OT_RESPONSE      8'hd0
`define CMD_STATUS_BYTE      8'h78
`define CMD_STATUS_WORD      8'h79
`define CMD_STATUS_VOUT      8'h7a

// ************************************
// field widths
// ************************************
`define W_VOUT               12
`define W_RATIO              12
`define W_VIN_THR            6
`define W_TEMP               8

// ************************************
// reset values
// ************************************
`define RST_VOUT_COMMAND     12'h1cc
`define RST_FB_RATIO         12'h28c
`define RST_VOUT_LOWER       12'h170
`define RST_VIN_START        6'h0c
`define RST_VIN_STOP         6'h0b
`define RST_OT_LIMIT         8'h91
`define RST_OPERATION        8'h80
`define RST_OT_RESPONSE      8'h00

// ************************************
// field positions
// ************************************
`define BIT_OPER_ON          7
`define BIT_OT_LATCH         0
`define BIT_SB_OFF           6
`define BIT_SB_TEMP          2
`define BIT_SW_VOUT          15
`define BIT_SV_MAXMIN        3

// ************************************
// thermal figures, timing and bus address
// ************************************
`define OT_SHUTDOWN_C        8'ha0
`define OT_RETRY_HYST_C      9'h014
`define OT_DETECT_MS         20
`define CLK_HZ               40000000
`define OT_DETECT_CYCLES     (`OT_DETECT_MS * (`CLK_HZ / 1000))
`define SMB_ADDR_DEFAULT     7'h20

`endif

// *** vout_limits_pkg.sv ***
package vout_limits_pkg;

	// serial management bus engine states
	typedef enum logic [3:0] {
		SMB_IDLE,
		SMB_ADDR,
		SMB_ADDR_ACK,
		SMB_CMD,
		SMB_CMD_ACK,
		SMB_WDATA,
		SMB_WDATA_ACK,
		SMB_RDATA,
		SMB_RDATA_ACK,
		SMB_SKIP
	} smb_state_t;

	// thermal protection states
	typedef enum logic {
		OT_NORMAL,
		OT_TRIPPED
	} ot_state_t;

endpackage : vout_limits_pkg

// *** sync2.sv ***
`timescale 1ns/1ps

// ************************************
// two-flop synchroniser
// ************************************
module sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= '1;
			q    <= '1;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule : sync2

// *** persist_filter.sv ***
`timescale 1ns/1ps

// ************************************
// persistence filter
// ************************************
module persist_filter #(
	parameter int COUNT = 4
) (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic level_in,
	output logic      level_out
);

	localparam int CW = $clog2(COUNT + 1);

	logic [CW-1:0] cnt;

	// output rises once input held COUNT cycles, falls at once
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt       <= '0;
			level_out <= 1'b0;
		end else if (!level_in) begin
			cnt       <= '0;
			level_out <= 1'b0;
		end else if (cnt == CW'(COUNT - 1)) begin
			level_out <= 1'b1;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

endmodule : persist_filter

// *** vout_limits_checker_properties.sv ***
`timescale 1ns/1ps
`include "vout_limits_params.svh"
// ****
// port checker
// ****
module vout_limits_checker #(
	parameter int OT_FILTER_CYC = 4
) (
	input wire logic               clk,
	input wire logic               arst_n,
	input wire logic               alert_out_n,
	input wire logic               alert_oe,
	input wire logic [7:0]         vin_meas,
	input wire logic [`W_TEMP-1:0] temp_meas,
	input wire logic               start_ok,
	input wire logic               conv_enable,
	input wire logic               thermal_shutdown
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// run of cycles at or above the fixed shutdown point
	int hot_cnt;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			hot_cnt <= 0;
		else if (temp_meas >= `OT_SHUTDOWN_C && hot_cnt < 1000)
			hot_cnt <= hot_cnt + 1;
		else if (temp_meas < `OT_SHUTDOWN_C)
			hot_cnt <= 0;
	end
	property p_alert_oe; alert_oe == !alert_out_n; endproperty
	a_alert_oe: assert property (p_alert_oe) else $error("alert enable mismatch");
	property p_ts_conv; thermal_shutdown [*3] |-> !conv_enable; endproperty
	a_ts_conv: assert property (p_ts_conv) else $error("running while tripped");
	property p_ts_alert; thermal_shutdown [*3] |-> !alert_out_n; endproperty
	a_ts_alert: assert property (p_ts_alert) else $error("no alert while tripped");
	property p_alert_rise; $rose(alert_out_n) |-> !thermal_shutdown; endproperty
	a_alert_rise: assert property (p_alert_rise) else $error("alert freed while tripped");
	property p_hot_trip; hot_cnt > OT_FILTER_CYC + 3 |-> thermal_shutdown; endproperty
	a_hot_trip: assert property (p_hot_trip) else $error("no shutdown at fixed point");
	property p_vin_zero; vin_meas == 8'h00 [*5] |-> !conv_enable; endproperty
	a_vin_zero: assert property (p_vin_zero) else $error("running with no input");
	property p_conv_start; $rose(conv_enable) |-> $past(start_ok, 2) && !thermal_shutdown;
	endproperty
	a_conv_start: assert property (p_conv_start) else $error("start without conditions");
	property p_trip_cause; $rose(thermal_shutdown) |-> $past(temp_meas) != 8'h00; endproperty
	a_trip_cause: assert property (p_trip_cause) else $error("trip at zero degrees");
endmodule : vout_limits_checker

bind vout_vin_ot_limit_registers vout_limits_checker #(
	.OT_FILTER_CYC(OT_FILTER_CYC)
) chk_i (
	.clk(clk),
	.arst_n(arst_n),
	.alert_out_n(alert_out_n),
	.alert_oe(alert_oe),
	.vin_meas(vin_meas),
	.temp_meas(temp_meas),
	.start_ok(start_ok),
	.conv_enable(conv_enable),
	.thermal_shutdown(thermal_shutdown)
);

// *** smb_host_model.sv ***
`timescale 1ns/1ps
// ****
// management bus host
// ****
module smb_host_model #(
	parameter logic [6:0] ADDR = 7'h20
) (
	input  wire logic clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda
);
	// both lines idle high behind pull-ups
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// data moves in the low phase, read at the end of high
	task automatic bit_io(input logic b, output logic r);
		scl <= 1'b0;
		tick(2);
		sda <= b;
		tick(2);
		scl <= 1'b1;
		tick(4);
		r = sda_line;
	endtask : bit_io
	task automatic byte_io(input logic [7:0] d, input logic nak, output logic [7:0] r);
		logic a;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(nak, a);
	endtask : byte_io
	// repeated start first lowers the clock so a held ack is let go
	task automatic start(input logic rep);
		if (rep) begin
			scl <= 1'b0;
			tick(4);
		end
		sda <= 1'b1;
		tick(2);
		scl <= 1'b1;
		tick(4);
		sda <= 1'b0;
		tick(4);
	endtask : start
	task automatic stop;
		scl <= 1'b0;
		tick(2);
		sda <= 1'b0;
		tick(2);
		scl <= 1'b1;
		tick(4);
		sda <= 1'b1;
		tick(4);
	endtask : stop
	task automatic head(input logic [7:0] c);
		logic [7:0] r;
		start(1'b0);
		byte_io({ADDR, 1'b0}, 1'b1, r);
		byte_io(c, 1'b1, r);
	endtask : head
	// low byte first; byte commands ignore the second
	task automatic wr_word(input logic [7:0] c, input logic [15:0] d);
		logic [7:0] r;
		head(c);
		byte_io(d[7:0], 1'b1, r);
		byte_io(d[15:8], 1'b1, r);
		stop();
	endtask : wr_word
	task automatic send(input logic [7:0] c);
		head(c);
		stop();
	endtask : send
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		head(c);
		start(1'b1);
		byte_io({ADDR, 1'b1}, 1'b1, d[7:0]);
		byte_io(8'hff, 1'b0, d[7:0]);
		byte_io(8'hff, 1'b1, d[15:8]);
		stop();
	endtask : rd
endmodule : smb_host_model

// *** tb_vout_vin_ot_limit_registers.sv ***
`timescale 1ns/1ps
`include "vout_limits_params.svh"
module tb_vout_vin_ot_limit_registers;
	localparam int FILT = 4;
	logic                          clk;
	logic                          arst_n;
	logic                          scl;
	logic                          sda_h;
	logic                          sda_out;
	logic                          sda_oe;
	logic                          alert_out_n;
	logic                          alert_oe;
	logic [7:0]                    vin_meas;
	logic [`W_TEMP-1:0]            temp_meas;
	logic                          start_ok;
	logic                          conv_enable;
	logic                          thermal_shutdown;
	logic [`W_VOUT-1:0]            vout_target;
	logic [`W_VOUT+`W_RATIO-1:0]   fb_ref;
	logic [15:0]                   rv;
	int                            n_fail;
	int                            check_count;
	int                            cyc;
	logic [7:0]  cmd [5] = '{8'h29, 8'h2b, 8'h35, 8'h36, 8'h4f};
	logic [15:0] dflt [5] = '{16'h028c, 16'h0170, 16'h000c, 16'h000b, 16'h0091};
	logic [15:0] msk [5] = '{16'h0fff, 16'h0fff, 16'h003f, 16'h003f, 16'h00ff};
	logic [7:0]  tvin [6] = '{8'h10, 8'h0f, 8'h10, 8'h0d, 8'h0c, 8'h0f};
	logic        tok [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
	logic        tcv [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
	// open-drain data line
	wire sda_line = sda_h & (sda_oe ? sda_out : 1'b1);
	smb_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda(sda_h));
	vout_vin_ot_limit_registers #(.OT_FILTER_CYC(FILT)) uut (
		.clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .alert_out_n(alert_out_n),
		.alert_oe(alert_oe), .vin_meas(vin_meas), .temp_meas(temp_meas),
		.start_ok(start_ok), .conv_enable(conv_enable),
		.thermal_shutdown(thermal_shutdown), .vout_target(vout_target), .fb_ref(fb_ref)
	);
	always #12.5 clk = ~clk;
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			close_out();
		end
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic settle;
		repeat (FILT + 8) @(posedge clk);
	endtask : settle
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	// main sequence
	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		vin_meas = 8'h00;
		temp_meas = 8'h19;
		start_ok = 1'b0;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk(fb_ref, 24'h1cc * 24'h28c);
		chk(alert_out_n, 1'b1);
		for (int i = 0; i < 5; i++) begin
			host.rd(cmd[i], rv);
			chk(rv, dflt[i]);
			host.wr_word(cmd[i], 16'hffff);
			host.rd(cmd[i], rv);
			chk(rv, msk[i]);
			host.wr_word(cmd[i], dflt[i]);
		end
		host.rd(8'h50, rv);
		chk(rv, 16'h0000);
		$display("test registers done");
		host.send(`CMD_CLEAR_FAULTS);
		host.wr_word(`CMD_FB_RATIO, 16'h03e8);
		host.wr_word(`CMD_VOUT_COMMAND, 16'h0200);
		settle();
		chk(vout_target, 12'h200);
		chk(fb_ref, 24'h200 * 24'h3e8);
		host.wr_word(`CMD_VOUT_COMMAND, 16'h0170);
		settle();
		chk(alert_out_n, 1'b1);
		host.wr_word(`CMD_VOUT_COMMAND, 16'h016f);
		settle();
		chk(vout_target, 12'h170);
		chk(fb_ref, 24'h170 * 24'h3e8);
		chk(alert_out_n, 1'b0);
		host.rd(`CMD_STATUS_VOUT, rv);
		chk(rv[3], 1'b1);
		host.rd(`CMD_STATUS_WORD, rv);
		chk(rv[15], 1'b1);
		host.send(`CMD_CLEAR_FAULTS);
		settle();
		chk(alert_out_n, 1'b1);
		$display("test clamp done");
		host.wr_word(`CMD_VIN_START, 16'h0010);
		host.wr_word(`CMD_VIN_STOP, 16'h000c);
		for (int i = 0; i < 6; i++) begin
			vin_meas <= tvin[i];
			start_ok <= tok[i];
			settle();
			chk(conv_enable, tcv[i]);
		end
		$display("test input window done");
		vin_meas <= 8'h10;
		temp_meas <= 8'h91;
		settle();
		chk(thermal_shutdown, 1'b0);
		chk(conv_enable, 1'b1);
		temp_meas <= 8'h92;
		settle();
		chk(thermal_shutdown, 1'b1);
		chk(conv_enable, 1'b0);
		chk(alert_out_n, 1'b0);
		host.rd(`CMD_STATUS_WORD, rv);
		chk(rv[2], 1'b1);
		temp_meas <= 8'h7d;
		settle();
		chk(thermal_shutdown, 1'b1);
		temp_meas <= 8'h7c;
		settle();
		chk(thermal_shutdown, 1'b0);
		chk(conv_enable, 1'b1);
		host.wr_word(`CMD_OT_RESPONSE, 16'h0001);
		temp_meas <= 8'h92;
		settle();
		temp_meas <= 8'h90;
		settle();
		chk(thermal_shutdown, 1'b1);
		host.wr_word(`CMD_OPERATION, 16'h0080);
		settle();
		chk(conv_enable, 1'b1);
		host.wr_word(`CMD_OT_LIMIT, 16'h00a5);
		temp_meas <= 8'h9f;
		settle();
		chk(thermal_shutdown, 1'b0);
		temp_meas <= 8'ha0;
		settle();
		chk(thermal_shutdown, 1'b1);
		$display("test thermal done");
		close_out();
	end
endmodule : tb_vout_vin_ot_limit_registers
